// File: verilog/iaw_pkg.sv
// Purpose: Shared constants and types of the interrupt arbiter with edge filter and watchdog
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per word
// Notes:   Source numbers 0..20 are the maskable sources in default order
package iaw_pkg;
   // ----------------------------------------------------------------
   // Sizes and source numbering
   // ----------------------------------------------------------------
   localparam int NUM_MSK = 21;
   localparam int WD_W = 21;
   localparam logic [4:0] SRC_NMI = 5'h15;
   localparam logic [4:0] SRC_WDT = 5'h16;
   localparam logic [4:0] SRC_OPERR = 5'h17;
   // Sources fed by pins, not by the peripheral request vector
   localparam logic [20:0] PIN_SRC_MASK = 21'h00180F;
   // Sources that may be handed to macro service (not 14 and 18)
   localparam logic [20:0] MACRO_OK = 21'h1BBFFF;
   // ----------------------------------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------------------------------
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_EDGE = 6'h04;
   localparam logic [5:0] REG_PRIO_LO = 6'h08;
   localparam logic [5:0] REG_PRIO_HI = 6'h0C;
   localparam logic [5:0] REG_CTXSW = 6'h10;
   localparam logic [5:0] REG_MACRO = 6'h14;
   localparam logic [5:0] REG_MASK = 6'h18;
   localparam logic [5:0] REG_PEND = 6'h1C;
   localparam logic [5:0] REG_WDCLR = 6'h20;
   localparam logic [5:0] REG_STAT = 6'h24;
   // CTRL fields
   localparam int CTRL_WD_EN = 0;
   localparam int CTRL_WD_SEL = 1;
   localparam int CTRL_WD_FIRST = 3;
   localparam int CTRL_NMI_RISE = 4;
   // EDGE fields: pins 0..3 two bits each, pins 4/5 one bit, sample select
   localparam int EDGE_PIN45 = 8;
   localparam int EDGE_SMP = 10;
   localparam logic [20:0] MASK_RST = 21'h1FFFFF;
   localparam logic [11:0] EDGE_RST = 12'h000;
   // ----------------------------------------------------------------
   // Vector table
   // ----------------------------------------------------------------
   localparam logic [15:0] VEC_NMI = 16'h0002;
   localparam logic [15:0] VEC_WDT = 16'h0004;
   localparam logic [15:0] VEC_MSK_BASE = 16'h0006;
   localparam logic [15:0] VEC_OPERR = 16'h003C;
   localparam logic [7:0] BYTE_ALL1 = 8'hFF;
   localparam logic [2:0] LVL_IDLE = 3'h4;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {MODE_VECT, MODE_CTXSW, MODE_MACRO} iaw_mode_t;
   typedef enum logic [1:0] {ARB_IDLE, ARB_OFFER, ARB_MACRO} iaw_arb_t;
   typedef struct packed {
      iaw_mode_t mode;
      logic [4:0] src;
      logic [1:0] level;
      logic [15:0] vector;
   } iaw_req_t;
   typedef struct packed {
      logic [6:0] sy1;
      logic [6:0] sy2;
      logic [3:0] smp;
      logic [3:0] flt;
      logic [2:0] lvl;
      logic [2:0] tick_cnt;
      logic [20:0] pend;
      logic nmi_pend;
      logic wdt_pend;
      logic operr_pend;
      logic [20:0] mask;
      logic [20:0] ctxsw;
      logic [20:0] macro;
      logic [41:0] prio;
      logic [11:0] edge_cfg;
      logic wd_en;
      logic [1:0] wd_sel;
      logic wd_first;
      logic nmi_rise;
      logic [20:0] wd_cnt;
      logic [3:0] isr;
      logic nmi_busy;
      iaw_arb_t arb;
      logic req_valid;
      iaw_req_t req;
      logic waitreq;
      logic [31:0] rdata;
      logic tm0_trig;
      logic tm1_trig;
      logic tm2_trig;
      logic adc_trig;
   } iaw_state_t;
endpackage

// File: verilog/iaw_top.sv
// Purpose: Interrupt arbiter with pin edge detection, noise filter and watchdog
// Assumes: Core acknowledges an offered request with a pulse; pins are synchronous inputs
// Notes:   Core side is offer, acknowledge and return pulses; no interrupt output of its own
// Functional notes
// - Four software priority levels govern nesting
// - Equal level resolved by lowest default number
// - Macro service runs to completion unsuspended
// - Twenty-three hardware sources besides software traps
// - Operand trap when byte XOR companion not FFh
// - NMI pin and watchdog nonmaskable, never macro
// - Uncleared watchdog overflows into nonmaskable request
// - Watchdog enable cannot be undone before reset
// - Software picks watchdog versus NMI pin priority
// - Request pins also trigger timers and converter
// - Pins zero to three: rising, falling, both
// - Pins zero to three filtered by clock sampling
// - Pin zero setting selects sampling clock; here EDGE bits 10-11 select it for pins 0-3
// - Pin zero: default 0, macro, timer one
// - Pins one to three: defaults 1 to 3
// - Timer zero matches take defaults 4, 5
// - Timers one, two matches take defaults 6-9
// - Vectored mode: core pushes PC and PSW
// - Context switch: bank save of PC, PSW
// - Macro service leaves PC and PSW untouched
// - Vectored branch uses source's vector table entry
// - Serial two transmit done has default 20
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module iaw_top
   import iaw_pkg::*;
#(
   parameter int WD_EXP0 = 17,
   parameter int WD_EXP1 = 19,
   parameter int WD_EXP2 = 20,
   parameter int WD_EXP3 = 21
) (
   input wire logic i_clk, // 25 MHz clock
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic [5:0] i_avs_address, // Byte address
   input wire logic i_avs_read, // Read request
   input wire logic i_avs_write, // Write request
   input wire logic [31:0] i_avs_writedata, // Write data
   input wire logic [3:0] i_avs_byteenable, // Byte lanes
   output logic [31:0] o_avs_readdata, // Read data
   output logic o_avs_waitrequest, // Low for the completing cycle
   input wire logic [5:0] i_ext_req_pin, // Request pins 0..5
   input wire logic i_nmi_pin, // Nonmaskable request pin
   input wire logic [20:0] i_periph_req, // Peripheral request pulses by source number
   input wire logic i_opchk_valid, // Core checks an operand byte pair
   input wire logic [7:0] i_opchk_byte, // Operand byte
   input wire logic [7:0] i_opchk_cmpl, // Companion byte
   input wire logic i_req_ack, // Core takes the offered request
   input wire logic i_reti, // Core returns from a handler
   input wire logic i_ms_done, // Macro transfer finished
   output logic o_req_valid, // Request offered to core
   output iaw_pkg::iaw_req_t o_req, // Offered request
   output logic o_tm0_trig, // Timer 0 capture/count event
   output logic o_tm1_trig, // Timer 1 capture/count event
   output logic o_tm2_trig, // Timer 2 capture/count event
   output logic o_adc_trig // Converter start event
);
   import iaw_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (WD_EXP0 < 1 || WD_EXP0 > WD_W || WD_EXP1 < 1 || WD_EXP1 > WD_W ||
       WD_EXP2 < 1 || WD_EXP2 > WD_W || WD_EXP3 < 1 || WD_EXP3 > WD_W) begin : g_bad_exp
      $error("watchdog exponent out of range");
   end

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b+:8] = wd[8*b+:8];
         end
      end
      return r;
   endfunction

   // Terminal count of the selected interval
   function automatic logic [20:0] wd_top(logic [1:0] sel);
      int e;
      case (sel)
         2'h0: e = WD_EXP0;
         2'h1: e = WD_EXP1;
         2'h2: e = WD_EXP2;
         default: e = WD_EXP3;
      endcase
      return (21'h000001 << e) - 21'h000001;
   endfunction

   function automatic logic [15:0] vec_of(logic [4:0] src);
      case (src)
         SRC_NMI: return VEC_NMI;
         SRC_WDT: return VEC_WDT;
         SRC_OPERR: return VEC_OPERR;
         default: return VEC_MSK_BASE + {10'h000, src, 1'b0};
      endcase
   endfunction

   // Lowest set bit of the in-service set, or idle
   function automatic logic [2:0] cur_level(logic [3:0] isr);
      logic [2:0] r;
      r = LVL_IDLE;
      for (int l = 3; l >= 0; l--) begin
         if (isr[l]) begin
            r = 3'(l);
         end
      end
      return r;
   endfunction

   // Returns {found, level, source}; lowest level wins, then lowest number
   function automatic logic [7:0] pick(logic [20:0] req, logic [41:0] prio);
      logic [7:0] r;
      r = 8'h00;
      for (int l = 3; l >= 0; l--) begin
         for (int i = NUM_MSK - 1; i >= 0; i--) begin
            if (req[i] && prio[2*i+:2] == 2'(l)) begin
               r = {1'b1, 2'(l), 5'(i)};
            end
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   iaw_state_t st;
   iaw_state_t nxt;
   logic rd_go;
   logic wr_go;
   logic [31:0] wdw;
   logic [3:0] smp_now;
   logic tick;
   logic [3:0] f_rise;
   logic [3:0] f_fall;
   logic [3:0] f_edge;
   logic [2:0] lv_now;
   logic [1:0] p45_edge;
   logic nmi_edge;
   logic [20:0] msk_set;
   logic [20:0] msk_clr;
   logic [20:0] eligible;
   logic [7:0] win;
   logic [2:0] lvl_cur;
   logic wd_ovf;
   logic wd_clr;

   always_comb begin
      nxt = st;
      // ----------------------------------------------------------------
      // Bus slave: one wait cycle, then the access completes
      // ----------------------------------------------------------------
      rd_go = i_avs_read && st.waitreq;
      wr_go = i_avs_write && !st.waitreq;
      nxt.waitreq = !((i_avs_read || i_avs_write) && st.waitreq);
      wdw = 32'h00000000;
      if (rd_go) begin
         case (i_avs_address)
            REG_CTRL: nxt.rdata = {27'h0, st.nmi_rise, st.wd_first, st.wd_sel, st.wd_en};
            REG_EDGE: nxt.rdata = {20'h0, st.edge_cfg};
            REG_PRIO_LO: nxt.rdata = st.prio[31:0];
            REG_PRIO_HI: nxt.rdata = {22'h0, st.prio[41:32]};
            REG_CTXSW: nxt.rdata = {11'h0, st.ctxsw};
            REG_MACRO: nxt.rdata = {11'h0, st.macro};
            REG_MASK: nxt.rdata = {11'h0, st.mask};
            REG_PEND: nxt.rdata = {11'h0, st.pend};
            // Live state: filtered pins, pendings, macro busy, nesting
            REG_STAT: nxt.rdata = {19'h0, st.flt, st.operr_pend, st.wdt_pend,
                                   st.nmi_pend, st.arb == ARB_MACRO, st.nmi_busy, st.isr};
            default: nxt.rdata = 32'h00000000;
         endcase
      end
      if (wr_go) begin
         case (i_avs_address)
            REG_CTRL: begin
               wdw = wmerge({27'h0, st.nmi_rise, st.wd_first, st.wd_sel, st.wd_en},
                            i_avs_writedata, i_avs_byteenable);
               nxt.wd_en = st.wd_en | wdw[CTRL_WD_EN];
               nxt.wd_sel = wdw[CTRL_WD_SEL+:2];
               nxt.wd_first = wdw[CTRL_WD_FIRST];
               nxt.nmi_rise = wdw[CTRL_NMI_RISE];
            end
            REG_EDGE: begin
               wdw = wmerge({20'h0, st.edge_cfg}, i_avs_writedata, i_avs_byteenable);
               nxt.edge_cfg = wdw[11:0];
            end
            REG_PRIO_LO: begin
               nxt.prio[31:0] = wmerge(st.prio[31:0], i_avs_writedata, i_avs_byteenable);
            end
            REG_PRIO_HI: begin
               wdw = wmerge({22'h0, st.prio[41:32]}, i_avs_writedata, i_avs_byteenable);
               nxt.prio[41:32] = wdw[9:0];
            end
            REG_CTXSW: begin
               wdw = wmerge({11'h0, st.ctxsw}, i_avs_writedata, i_avs_byteenable);
               nxt.ctxsw = wdw[20:0];
            end
            REG_MACRO: begin
               wdw = wmerge({11'h0, st.macro}, i_avs_writedata, i_avs_byteenable);
               nxt.macro = wdw[20:0] & MACRO_OK;
            end
            REG_MASK: begin
               wdw = wmerge({11'h0, st.mask}, i_avs_writedata, i_avs_byteenable);
               nxt.mask = wdw[20:0];
            end
            default: wdw = 32'h00000000;
         endcase
      end

      // ----------------------------------------------------------------
      // Pin synchronisers and clock-sampling noise filter
      // ----------------------------------------------------------------
      nxt.sy1 = {i_nmi_pin, i_ext_req_pin};
      nxt.sy2 = st.sy1;
      nxt.tick_cnt = st.tick_cnt + 3'h1;
      // Sample period 1, 2, 4 or 8 clocks, chosen by EDGE bits 10-11, beside the pin 4/5 bits
      case (st.edge_cfg[EDGE_SMP+:2])
         2'h0: tick = 1'b1;
         2'h1: tick = st.tick_cnt[0];
         2'h2: tick = &st.tick_cnt[1:0];
         default: tick = &st.tick_cnt;
      endcase
      smp_now = st.sy2[3:0];
      if (tick) begin
         nxt.smp = smp_now;
         // A level is accepted only after two equal samples in a row
         nxt.flt = (st.flt & (smp_now ^ st.smp)) | (smp_now & st.smp);
      end
      f_rise = nxt.flt & ~st.flt;
      f_fall = ~nxt.flt & st.flt;
      for (int p = 0; p < 4; p++) begin
         f_edge[p] = (f_rise[p] && st.edge_cfg[2*p]) || (f_fall[p] && st.edge_cfg[2*p+1]);
      end
      // Pins 4, 5 and the nonmaskable pin rely on the pad's analog delay
      lv_now = {st.sy2[6], st.sy2[5:4]};
      nxt.lvl = lv_now;
      for (int p = 0; p < 2; p++) begin
         p45_edge[p] = st.edge_cfg[EDGE_PIN45+p] ? (lv_now[p] && !st.lvl[p])
                                                  : (!lv_now[p] && st.lvl[p]);
      end
      nmi_edge = st.nmi_rise ? (lv_now[2] && !st.lvl[2]) : (!lv_now[2] && st.lvl[2]);
      // Pin events double as peripheral triggers
      nxt.tm1_trig = f_edge[0];
      nxt.tm2_trig = f_edge[1] | f_edge[2];
      nxt.tm0_trig = f_edge[3];
      nxt.adc_trig = p45_edge[1];

      // ----------------------------------------------------------------
      // Watchdog
      // ----------------------------------------------------------------
      wd_clr = wr_go && i_avs_address == REG_WDCLR;
      wd_ovf = st.wd_en && !wd_clr && st.wd_cnt == wd_top(st.wd_sel);
      if (wd_clr || wd_ovf) begin
         nxt.wd_cnt = 21'h000000;
      end else if (st.wd_en) begin
         nxt.wd_cnt = st.wd_cnt + 21'h000001;
      end

      // ----------------------------------------------------------------
      // Pending flags: a new event wins over any clear in the same cycle
      // ----------------------------------------------------------------
      // Default numbers: pins 0-3, timer matches 4-9 via peripheral vector
      msk_set = (i_periph_req & ~PIN_SRC_MASK)
                | {8'h00, p45_edge, 7'h00, f_edge};
      msk_clr = 21'h000000;
      if (wr_go && i_avs_address == REG_PEND) begin
         wdw = wmerge(32'h00000000, i_avs_writedata, i_avs_byteenable);
         msk_clr = wdw[20:0];
      end
      lvl_cur = cur_level(st.isr);
      eligible = st.pend & ~st.mask;
      for (int i = 0; i < NUM_MSK; i++) begin
         // Only a strictly more urgent level may nest
         if ({1'b0, st.prio[2*i+:2]} >= lvl_cur) begin
            eligible[i] = 1'b0;
         end
      end
      win = pick(eligible, st.prio);

      // ----------------------------------------------------------------
      // Arbiter and hand-off to the core
      // ----------------------------------------------------------------
      if (i_reti) begin
         if (st.nmi_busy) begin
            nxt.nmi_busy = 1'b0;
         end else if (lvl_cur != LVL_IDLE) begin
            nxt.isr[lvl_cur[1:0]] = 1'b0;
         end
      end
      case (st.arb)
         ARB_IDLE: begin
            nxt.req.level = 2'h0;
            nxt.req.mode = MODE_VECT;
            if (st.operr_pend) begin
               nxt.req.src = SRC_OPERR;
               nxt.req_valid = 1'b1;
            end else if (st.nmi_pend || st.wdt_pend) begin
               // Nonmaskable sources are always vectored
               nxt.req.src = (st.wdt_pend && (st.wd_first || !st.nmi_pend)) ? SRC_WDT
                                                                            : SRC_NMI;
               nxt.req_valid = 1'b1;
            end else if (win[7] && !st.nmi_busy) begin
               nxt.req.src = win[4:0];
               nxt.req.level = win[6:5];
               if (st.macro[win[4:0]]) begin
                  nxt.req.mode = MODE_MACRO;
               end else if (st.ctxsw[win[4:0]]) begin
                  nxt.req.mode = MODE_CTXSW;
               end else begin
                  nxt.req.mode = MODE_VECT;
               end
               nxt.req_valid = 1'b1;
            end
            nxt.req.vector = vec_of(nxt.req.src);
            if (nxt.req_valid) begin
               nxt.arb = ARB_OFFER;
            end
         end
         ARB_OFFER: begin
            if (i_req_ack) begin
               nxt.req_valid = 1'b0;
               nxt.arb = ARB_IDLE;
               if (st.req.src == SRC_OPERR) begin
                  nxt.operr_pend = 1'b0;
                  nxt.nmi_busy = 1'b1;
               end else if (st.req.src == SRC_NMI) begin
                  nxt.nmi_pend = 1'b0;
                  nxt.nmi_busy = 1'b1;
               end else if (st.req.src == SRC_WDT) begin
                  nxt.wdt_pend = 1'b0;
                  nxt.nmi_busy = 1'b1;
               end else begin
                  msk_clr[st.req.src] = 1'b1;
                  if (st.req.mode == MODE_MACRO) begin
                     nxt.arb = ARB_MACRO;
                  end else begin
                     nxt.isr[st.req.level] = 1'b1;
                  end
               end
            end
         end
         ARB_MACRO: begin
            // Nothing is offered until the transfer ends
            if (i_ms_done) begin
               nxt.arb = ARB_IDLE;
            end
         end
         default: nxt.arb = ARB_IDLE;
      endcase
      nxt.pend = (st.pend & ~msk_clr) | msk_set;
      if (nmi_edge) begin
         nxt.nmi_pend = 1'b1;
      end
      if (wd_ovf) begin
         nxt.wdt_pend = 1'b1;
      end
      if (i_opchk_valid && (i_opchk_byte ^ i_opchk_cmpl) != BYTE_ALL1) begin
         nxt.operr_pend = 1'b1;
      end

      // ----------------------------------------------------------------
      // Reset
      // ----------------------------------------------------------------
      if (i_rst) begin
         nxt = '0;
         nxt.waitreq = 1'b1;
         nxt.mask = MASK_RST;
         nxt.edge_cfg = EDGE_RST;
         nxt.arb = ARB_IDLE;
      end
   end

   always_ff @(posedge i_clk) begin
      st <= nxt;
   end

   assign o_avs_readdata = st.rdata;
   assign o_avs_waitrequest = st.waitreq;
   assign o_req_valid = st.req_valid;
   assign o_req = st.req;
   assign o_tm0_trig = st.tm0_trig;
   assign o_tm1_trig = st.tm1_trig;
   assign o_tm2_trig = st.tm2_trig;
   assign o_adc_trig = st.adc_trig;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence ms_entry;
      st.req_valid && i_req_ack && st.req.mode == MODE_MACRO;
   endsequence
   sequence ms_stay;
      (st.arb == ARB_MACRO && !st.req_valid) [*2];
   endsequence

   bus_wait_a: assert property ((i_avs_read || i_avs_write) && st.waitreq |=> !st.waitreq)
      else $error("bus answer late");
   // Only cycles without a done pulse are judged, so any transfer length is legal
   macro_run_a: assert property (ms_entry ##1 (!i_ms_done) [*2] |-> ms_stay)
      else $error("macro service suspended");
   wd_lock_a: assert property (st.wd_en |=> st.wd_en)
      else $error("watchdog disabled");
   wd_overflow_a: assert property (wd_ovf |=> st.wdt_pend && st.wd_cnt == 21'h000000)
      else $error("watchdog overflow lost");
   operand_trap_a: assert property (i_opchk_valid &&
      (i_opchk_byte ^ i_opchk_cmpl) != BYTE_ALL1 |=> st.operr_pend)
      else $error("operand trap lost");
   nmi_no_macro_a: assert property (st.req_valid && st.req.src > 5'h14 |->
      st.req.mode == MODE_VECT)
      else $error("nonmaskable routed to macro");
   pin0_trig_a: assert property ($rose(st.flt[0]) &&
      $past(st.edge_cfg[0]) |-> st.tm1_trig)
      else $error("pin 0 trigger missing");
   vector_addr_a: assert property (st.req_valid && st.req.src < 5'h15 |->
      st.req.vector == VEC_MSK_BASE + {10'h000, st.req.src, 1'b0})
      else $error("wrong vector");
   nest_level_a: assert property ($rose(st.req_valid) &&
      $past(st.req_valid == 1'b0) && st.req.src < 5'h15 |->
      {1'b0, st.req.level} < $past(lvl_cur))
      else $error("illegal nesting");
   wd_pref_a: assert property ($rose(st.req_valid) &&
      $past(st.nmi_pend && st.wdt_pend && !st.operr_pend) |->
      st.req.src == ($past(st.wd_first) ? SRC_WDT : SRC_NMI))
      else $error("nonmaskable order wrong");
endmodule

// File: verif/iaw_core_model.sv
// Purpose: Core model taking offers and returning from handlers
// Assumes: Offer is acknowledged DLY+1 cycles after it appears
// Notes: Returns wait for i_ret_go so handlers can be kept open
`timescale 1ns/100ps
module iaw_core_model
   import iaw_pkg::*;
#(parameter int DLY = 2) (
   input wire logic i_clk, // Clock
   input wire logic i_ret_go, // Handlers may return
   input wire logic i_req_valid, // Offer
   input wire iaw_pkg::iaw_req_t i_req, // Offered request
   output logic o_req_ack = 0, // Take pulse
   output logic o_reti = 0, // Return pulse
   output logic o_ms_done = 0, // Macro done pulse
   output iaw_pkg::iaw_req_t o_taken = '0, // Last taken
   output int o_cnt = 0 // Taken count
);
   int wt = 0;
   int nest = 0;
   int ms = 0;
   always @(posedge i_clk) begin
      wt <= (i_req_valid && !o_req_ack) ? wt + 1 : 0;
      o_req_ack <= i_req_valid && !o_req_ack && wt >= DLY;
      o_ms_done <= ms == 1;
      if (ms > 0) ms <= ms - 1;
      o_reti <= !o_reti && i_ret_go && nest > 0;
      // One update of the depth so a take and a return in one cycle both count
      nest <= nest + ((o_req_ack && i_req.mode != MODE_MACRO) ? 1 : 0) - (o_reti ? 1 : 0);
      if (o_req_ack) begin
         o_taken <= i_req;
         o_cnt <= o_cnt + 1;
         if (i_req.mode == MODE_MACRO) ms <= 3;
      end
   end
endmodule

// File: verif/iaw_top_bench.sv
// Purpose: Self-checking bench of the interrupt arbiter
// Assumes: Watchdog exponents 4..7 keep intervals short
// Notes: Watchdog scenario runs last as it keeps firing
`timescale 1ns/100ps
module iaw_top_bench;
   import iaw_pkg::*;
   logic i_clk = 0, i_rst = 1, rd = 0, wr = 0, wq, ov = 0, go = 1, ack, rt, md, vl, nmi = 0;
   logic [3:0] be = 4'hF;
   wire [3:0] tg;
   logic [5:0] ad = '0, pin = '0;
   logic [31:0] wd = '0, rq, q;
   logic [20:0] per = '0;
   logic [7:0] ob = '0, oc = '0;
   iaw_req_t rqs, tk;
   int cnt, fail_count = 0, comparisons = 0;
   int tc[4];
   always #20 i_clk = ~i_clk;
   always @(posedge i_clk)
      for (int j = 0; j < 4; j++) if (tg[j] === 1'b1) tc[j] <= tc[j] + 1;
   iaw_top #(.WD_EXP0(4), .WD_EXP1(5), .WD_EXP2(6), .WD_EXP3(7)) DUT (.i_clk(i_clk),
      .i_rst(i_rst), .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rq),
      .o_avs_waitrequest(wq), .i_ext_req_pin(pin), .i_nmi_pin(nmi), .i_periph_req(per),
      .i_opchk_valid(ov), .i_opchk_byte(ob), .i_opchk_cmpl(oc), .i_req_ack(ack),
      .i_reti(rt), .i_ms_done(md), .o_req_valid(vl), .o_req(rqs), .o_tm0_trig(tg[0]),
      .o_tm1_trig(tg[1]), .o_tm2_trig(tg[2]), .o_adc_trig(tg[3]));
   iaw_core_model CORE (.i_clk(i_clk), .i_ret_go(go), .i_req_valid(vl), .i_req(rqs),
      .o_req_ack(ack), .o_reti(rt), .o_ms_done(md), .o_taken(tk), .o_cnt(cnt));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge i_clk);
      ad <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge i_clk); while (wq !== 1'b0);
      q = rq;
      wr <= 0;
      rd <= 0;
   endtask
   task automatic take(input logic [4:0] s, input logic [15:0] v,
                       input iaw_mode_t m = MODE_VECT);
      int n;
      n = cnt;
      for (int i = 0; i < 300 && cnt == n; i++) @(posedge i_clk);
      chk("taken", n + 1, cnt);
      chk("req", {m, s, v}, {tk.mode, tk.src, tk.vector});
   endtask
   task automatic none(input int k);
      int n;
      n = cnt;
      repeat (k) @(posedge i_clk);
      chk("none", n, cnt);
   endtask
   task automatic pulse(input logic [20:0] m);
      @(posedge i_clk);
      per <= m;
      @(posedge i_clk);
      per <= '0;
   endtask
   task automatic t_order();
      bus(0, REG_MASK, '0);
      chk("mask", MASK_RST, q);
      bus(0, 6'h3C, '0);
      chk("unmapped", '0, q);
      bus(1, REG_MASK, '0);
      pulse(21'h100250);
      take(5'h04, 16'h000E);
      take(5'h06, 16'h0012);
      take(5'h09, 16'h0018);
      take(5'h14, 16'h002E);
   endtask
   task automatic t_level();
      bus(1, REG_PRIO_LO, 32'h55555555);
      bus(1, REG_PRIO_HI, 32'h00000055);
      go <= 0;
      pulse(21'h000010);
      take(5'h04, 16'h000E);
      pulse(21'h100000);
      take(5'h14, 16'h002E);
      pulse(21'h000020);
      none(20);
      go <= 1;
      take(5'h05, 16'h0010);
   endtask
   task automatic t_mode();
      bus(1, REG_MACRO, 32'h00000010);
      be <= 4'h1;
      bus(1, REG_CTXSW, 32'hFFFFFF20);
      be <= 4'hF;
      bus(0, REG_CTXSW, '0);
      chk("ctxsw", 32'h00000020, q);
      pulse(21'h000030);
      take(5'h04, 16'h000E, MODE_MACRO);
      take(5'h05, 16'h0010, MODE_CTXSW);
      bus(1, REG_MACRO, '0);
      bus(1, REG_CTXSW, '0);
   endtask
   task automatic t_oper(input logic [7:0] c);
      @(posedge i_clk);
      ov <= 1;
      ob <= 8'h12;
      oc <= c;
      @(posedge i_clk);
      ov <= 0;
   endtask
   task automatic t_pins();
      int n;
      int c[4];
      for (int m = 1; m < 4; m++) begin
         bus(1, REG_EDGE, m);
         n = tc[1];
         pin <= 6'h01;
         repeat (12) @(posedge i_clk);
         pin <= 6'h00;
         repeat (12) @(posedge i_clk);
         chk("edges", (m == 3) ? 2 : 1, tc[1] - n);
      end
      // A three-cycle pulse passes at the fastest sampling and is lost at the slowest
      for (int s = 0; s < 2; s++) begin
         bus(1, REG_EDGE, s ? 32'h00000C03 : 32'h00000003);
         n = tc[1];
         pin <= 6'h01;
         repeat (3) @(posedge i_clk);
         pin <= 6'h00;
         repeat (30) @(posedge i_clk);
         chk("glitch", s ? 0 : 2, tc[1] - n);
      end
      bus(1, REG_EDGE, 32'h00000244);
      c = tc;
      pin <= 6'h2A;
      repeat (12) @(posedge i_clk);
      pin <= 6'h00;
      repeat (12) @(posedge i_clk);
      foreach (c[j]) chk("trig", (j == 1) ? 0 : 1, tc[j] - c[j]);
   endtask
   task automatic t_wdt();
      int n;
      nmi <= 1;
      bus(1, REG_CTRL, 32'h00000009);
      n = cnt;
      repeat (8) bus(1, REG_WDCLR, '0);
      repeat (13) @(posedge i_clk);
      chk("cleared", n, cnt);
      // Pin falls now so that both nonmaskable flags rise on the overflow edge
      nmi <= 0;
      take(SRC_WDT, VEC_WDT);
      take(SRC_NMI, VEC_NMI);
      bus(1, REG_CTRL, '0);
      take(SRC_WDT, VEC_WDT);
   endtask
   task automatic test_done();
      if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_rst <= 0;
      t_order();
      t_level();
      t_mode();
      t_oper(8'hED);
      none(10);
      t_oper(8'h00);
      take(SRC_OPERR, VEC_OPERR);
      t_pins();
      t_wdt();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      test_done();
   end
endmodule
